// *** rtl/spfm_dev_end.sv ***
// Module end: presence status, indicators, fault interrupt and register reads
// Function
// R1 - Interrupt when all-valid changes to any-invalid
// R2 - Requests and acknowledges use backplane interrupt lines
// R3 - Handler favours lowest slot on shared line
// R4 - Seven selectable request levels, 7 highest
// R5 - Level 1 by default
// R6 - Both level selectors set to same level
// R7 - Status read at offset 4 of logical address
// R8 - All channels valid reads 20460
// R9 - No signal anywhere reads 16396
// R10 - Input loss turns all indicators off
// R11 - Shorted output: indicator off, status inactive
// R12 - Presence flags in status bits 5 to 11
// R13 - Any loss raises fault flag to interface
// R14 - Status readable at any time
// R15 - Logical address from selector, default 8
`timescale 1ns/1ps
module spfm_dev_end (
  input  wire logic       pclk,         // System clock, 20 MHz
  input  wire logic       presetn,      // Asynchronous reset, active low
  spfm_link_if.dev        link,         // Backplane link
  input  wire logic [6:0] det_raw,      // Peak detector levels, bit 0 input
  input  wire logic [2:0] req_lvl_sel,  // Request level jumper, 0 = default
  input  wire logic [2:0] ack_lvl_sel,  // Acknowledge level jumper
  input  wire logic [7:0] laddr_sel,    // Logical address switch
  output logic      [6:0] led_on,       // Presence indicators, bit 0 input
  output logic            fault         // Loss of signal on any channel
);

  localparam int unsigned SW = 21;

  logic [SW-1:0] pins_sync;
  logic [6:0]    det_s;
  logic [2:0]    req_sel_s;
  logic [2:0]    ack_sel_s;
  logic [7:0]    laddr_s;
  logic [6:0]    ch_ok;
  logic          all_ok;
  logic [15:0]   status;
  logic          rd_hit;
  logic          iack_hit;

  logic [6:0]    led_ff;
  logic          fault_ff;
  logic          all_ok_ff;
  logic          ok_seen_ff;
  logic          pend_ff;
  logic [2:0]    req_lvl_ff;
  logic [2:0]    ack_lvl_ff;
  logic [7:0]    laddr_ff;
  logic          ack_ff;
  logic [15:0]   data_ff;
  logic [7:1]    oe_ff;
  logic [7:1]    out_ff;

  // A zero jumper reading means the jumper pair is absent
  function automatic logic [2:0] norm_lvl(input logic [2:0] sel);
    norm_lvl = (sel == 3'h0) ? spfm_pkg::DEF_LEVEL : sel; // R5
  endfunction

  function automatic logic [15:0] make_status(input logic [6:0] ok);
    logic [15:0] flags;
    flags = {9'h000, ok} << spfm_pkg::CH_LSB; // R12
    make_status = spfm_pkg::STAT_BASE | flags; // R8 R9
  endfunction

  spfm_sync #(
    .W (SW)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_async ({laddr_sel, ack_lvl_sel, req_lvl_sel, det_raw}),
    .q_sync  (pins_sync)
  );

  assign det_s     = pins_sync[6:0];
  assign req_sel_s = pins_sync[9:7];
  assign ack_sel_s = pins_sync[12:10];
  assign laddr_s   = pins_sync[20:13];

  // The amplifier feeds every output from the input, so an output
  // cannot count as present while the input is gone
  assign ch_ok  = {det_s[6:1] & {6{det_s[0]}}, det_s[0]}; // R10 R11
  assign all_ok = &ch_ok;
  assign status = make_status(led_ff); // R14

  assign rd_hit   = link.rd_req && !ack_ff &&
                    (link.rd_la == laddr_ff); // R7
  assign iack_hit = link.iack_req && !ack_ff && pend_ff &&
                    (link.iack_lvl == ack_lvl_ff); // R2 R6

  // Indicators and fault flag follow the detector pins three cycles late, through the synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_ff <= 7'h00;
    end else begin
      led_ff <= ch_ok; // R10 R11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_ff <= 1'b0;
    end else begin
      fault_ff <= !all_ok; // R13
    end
  end

  // Straps are re-read every cycle; jumpers only move with power off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_lvl_ff <= spfm_pkg::DEF_LEVEL;
    end else begin
      req_lvl_ff <= norm_lvl(req_sel_s); // R4 R5
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_lvl_ff <= spfm_pkg::DEF_LEVEL;
    end else begin
      ack_lvl_ff <= norm_lvl(ack_sel_s); // R4 R6
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      laddr_ff <= spfm_pkg::DEF_LADDR;
    end else begin
      laddr_ff <= (laddr_s == 8'h00) ? spfm_pkg::DEF_LADDR
                                     : laddr_s; // R15
    end
  end

  // The synchroniser reads all-low just after reset; ok_seen keeps
  // that start-up state from being taken as a valid-to-invalid edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      all_ok_ff <= 1'b0;
    end else begin
      all_ok_ff <= all_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ok_seen_ff <= 1'b0;
    end else begin
      ok_seen_ff <= ok_seen_ff | all_ok;
    end
  end

  // Pending request: a new loss wins over an acknowledge in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= 1'b0;
    end else if (ok_seen_ff && all_ok_ff && !all_ok) begin
      pend_ff <= 1'b1; // R1 R13
    end else if (iack_hit) begin
      pend_ff <= 1'b0; // R2
    end
  end

  // Open-drain request lines: only the selected level is pulled low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ff <= 7'h00;
    end else begin
      out_ff <= 7'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_ff <= 7'h00;
    end else begin
      for (int i = 1; i <= spfm_pkg::NUM_LVL; i++) begin
        oe_ff[i] <= pend_ff && (req_lvl_ff == 3'(i)); // R2 R4
      end
    end
  end

  // Link answers: one-cycle acknowledge, data held until the next one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= rd_hit || iack_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_ff <= 16'h0000;
    end else if (rd_hit) begin
      data_ff <= (link.rd_off == spfm_pkg::STAT_OFF) ? status
                 : spfm_pkg::UNMAPPED_RD; // R7 R14
    end else if (iack_hit) begin
      data_ff <= status; // R2
    end
  end

  assign link.dev_ack  = ack_ff;
  assign link.dev_data = data_ff;
  assign link.irq_oe   = oe_ff;
  assign link.irq_out  = out_ff;
  assign led_on        = led_ff;
  assign fault         = fault_ff;

endmodule // spfm_dev_end

// *** rtl/spfm_host_end.sv ***
// Command module end: APB registers, status reads and interrupt service
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module spfm_host_end (
  input  wire logic        pclk,     // System clock, 20 MHz
  input  wire logic        presetn,  // Asynchronous reset, active low
  spfm_link_if.host        link,     // Backplane link
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB access phase
  input  wire logic        pwrite,   // APB write
  input  wire logic [7:0]  paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr,  // APB error, unmapped address
  output logic             irq       // Level interrupt, active high
);

  spfm_pkg::spfm_host_st_t st_ff;

  logic [31:0] ctrl_ff;
  logic        go_ff;
  logic [15:0] rdata_ff;
  logic [1:0]  istat_ff;
  logic [1:0]  imask_ff;
  logic [15:0] vec_ff;
  logic [2:0]  vlvl_ff;
  logic        rd_req_ff;
  logic        iack_req_ff;
  logic [2:0]  iack_lvl_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        irq_ff;
  logic        wr_en;
  logic        setup;
  logic [7:1]  lines;
  logic [1:0]  ev;

  // Highest asserted level wins; slot order within a level is the
  // daisy chain's business, not ours
  function automatic logic [2:0] top_level(input logic [7:1] act);
    top_level = 3'h0;
    for (int i = 1; i <= spfm_pkg::NUM_LVL; i++) begin
      if (act[i]) begin
        top_level = 3'(i); // R3 R4
      end
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == spfm_pkg::HREG_CTRL) || (a == spfm_pkg::HREG_RDATA) ||
             (a == spfm_pkg::HREG_ISTAT) || (a == spfm_pkg::HREG_IMASK) ||
             (a == spfm_pkg::HREG_VECTOR) || (a == spfm_pkg::HREG_IRQLN);
  endfunction

  assign lines = ~link.irq_n;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_ff && pwrite;

  assign ev[spfm_pkg::IRQ_RD_DONE]  = (st_ff == spfm_pkg::SPFM_READ) &&
                                      link.dev_ack;
  assign ev[spfm_pkg::IRQ_SERVICED] = (st_ff == spfm_pkg::SPFM_IACK) &&
                                      link.dev_ack;

  // One wait-free access: ready and data are prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup && !mapped(paddr);
      prdata_ff  <= 32'h0000_0000;
      if (setup && !pwrite) begin
        case (paddr)
          spfm_pkg::HREG_CTRL:   prdata_ff <= ctrl_ff;
          spfm_pkg::HREG_RDATA:  prdata_ff <= {15'h0000,
                                   st_ff != spfm_pkg::SPFM_IDLE || go_ff,
                                   rdata_ff};
          spfm_pkg::HREG_ISTAT:  prdata_ff <= {30'h0, istat_ff};
          spfm_pkg::HREG_IMASK:  prdata_ff <= {30'h0, imask_ff};
          spfm_pkg::HREG_VECTOR: prdata_ff <= {13'h0000, vlvl_ff, vec_ff};
          spfm_pkg::HREG_IRQLN:  prdata_ff <= {24'h000000, lines, 1'b0};
          default:               prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff  <= spfm_pkg::CTRL_RESET;
      imask_ff <= 2'h0;
    end else if (wr_en && paddr == spfm_pkg::HREG_CTRL) begin
      ctrl_ff <= {16'h0000, pwdata[15:0]};
    end else if (wr_en && paddr == spfm_pkg::HREG_IMASK) begin
      imask_ff <= pwdata[1:0];
    end
  end

  // Write-one-to-clear; an event in the same cycle keeps its bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_ff <= 2'h0;
    end else if (wr_en && paddr == spfm_pkg::HREG_ISTAT) begin
      istat_ff <= (istat_ff & ~pwdata[1:0]) | ev;
    end else begin
      istat_ff <= istat_ff | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(istat_ff & imask_ff);
    end
  end

  // Sequencer: interrupts are serviced before a waiting status read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff       <= spfm_pkg::SPFM_IDLE;
      go_ff       <= 1'b0;
      rd_req_ff   <= 1'b0;
      iack_req_ff <= 1'b0;
      iack_lvl_ff <= 3'h0;
      rdata_ff    <= 16'h0000;
      vec_ff      <= 16'h0000;
      vlvl_ff     <= 3'h0;
    end else begin
      if (wr_en && paddr == spfm_pkg::HREG_CTRL &&
          pwdata[spfm_pkg::CTRL_GO_BIT]) begin
        go_ff <= 1'b1;
      end
      case (st_ff)
        spfm_pkg::SPFM_IDLE: begin
          if (|lines) begin
            iack_req_ff <= 1'b1; // R2
            iack_lvl_ff <= top_level(lines);
            st_ff       <= spfm_pkg::SPFM_IACK;
          end else if (go_ff) begin
            go_ff     <= 1'b0;
            rd_req_ff <= 1'b1; // R7 R14
            st_ff     <= spfm_pkg::SPFM_READ;
          end
        end
        spfm_pkg::SPFM_READ: begin
          if (link.dev_ack) begin
            rd_req_ff <= 1'b0;
            rdata_ff  <= link.dev_data;
            st_ff     <= spfm_pkg::SPFM_IDLE;
          end
        end
        spfm_pkg::SPFM_IACK: begin
          if (link.dev_ack) begin
            iack_req_ff <= 1'b0;
            vec_ff      <= link.dev_data;
            vlvl_ff     <= iack_lvl_ff;
            st_ff       <= spfm_pkg::SPFM_IDLE;
          end
        end
        default: begin
          rd_req_ff   <= 1'b0;
          iack_req_ff <= 1'b0;
          st_ff       <= spfm_pkg::SPFM_IDLE;
        end
      endcase
    end
  end

  assign link.rd_req   = rd_req_ff;
  assign link.rd_la    = ctrl_ff[spfm_pkg::CTRL_LA_LSB +: 8];
  assign link.rd_off   = ctrl_ff[spfm_pkg::CTRL_OFF_LSB +: 8];
  assign link.iack_req = iack_req_ff;
  assign link.iack_lvl = iack_lvl_ff;
  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign irq           = irq_ff;

endmodule // spfm_host_end

// *** rtl/spfm_link_if.sv ***
// Backplane link between the monitor module and its command module
`timescale 1ns/1ps
interface spfm_link_if;
  logic        rd_req;    // Register read request
  logic [7:0]  rd_la;     // Logical address of the target
  logic [7:0]  rd_off;    // Register offset
  logic        iack_req;  // Interrupt acknowledge cycle
  logic [2:0]  iack_lvl;  // Level being acknowledged
  logic        dev_ack;   // One-cycle answer from the module
  logic [15:0] dev_data;  // Read data or status vector
  logic [7:1]  irq_out;   // Request line output values
  logic [7:1]  irq_oe;    // Request line output enables
  logic [7:1]  irq_n;     // Resolved open-drain request lines

  assign irq_n = ~(irq_oe & ~irq_out);

  modport dev (
    input  rd_req, rd_la, rd_off, iack_req, iack_lvl,
    output dev_ack, dev_data, irq_out, irq_oe
  );
  modport host (
    output rd_req, rd_la, rd_off, iack_req, iack_lvl,
    input  dev_ack, dev_data, irq_n
  );
endinterface

// *** rtl/spfm_pkg.sv ***
// Shared constants for the signal presence fault monitor and its controller
package spfm_pkg;

  // Channel layout: channel 0 is the input, channels 1..6 the outputs
  localparam int unsigned NUM_CH       = 7;
  localparam int unsigned CH_LSB       = 5;
  localparam int unsigned NUM_LVL      = 7;

  // Device register space
  localparam logic [7:0]  STAT_OFF     = 8'h04;
  localparam logic [15:0] STAT_BASE    = 16'h400c;
  localparam logic [15:0] STAT_ALL_OK  = 16'h4fec;
  localparam logic [15:0] UNMAPPED_RD  = 16'h0000;

  // Strap defaults
  localparam logic [2:0]  DEF_LEVEL    = 3'h1;
  localparam logic [7:0]  DEF_LADDR    = 8'h08;

  // Controller register map, byte addresses
  localparam logic [7:0]  HREG_CTRL    = 8'h00;
  localparam logic [7:0]  HREG_RDATA   = 8'h04;
  localparam logic [7:0]  HREG_ISTAT   = 8'h08;
  localparam logic [7:0]  HREG_IMASK   = 8'h0c;
  localparam logic [7:0]  HREG_VECTOR  = 8'h10;
  localparam logic [7:0]  HREG_IRQLN   = 8'h14;

  // CTRL fields
  localparam int unsigned CTRL_LA_LSB  = 0;
  localparam int unsigned CTRL_OFF_LSB = 8;
  localparam int unsigned CTRL_GO_BIT  = 16;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0408;

  // RDATA / VECTOR fields
  localparam int unsigned BUSY_BIT     = 16;
  localparam int unsigned VLVL_LSB     = 16;

  // Interrupt status bits
  localparam int unsigned IRQ_RD_DONE  = 0;
  localparam int unsigned IRQ_SERVICED = 1;
  localparam int unsigned NUM_IRQ      = 2;

  // Controller sequencer, Gray along idle -> read/ack -> idle
  typedef enum logic [1:0] {
    SPFM_IDLE = 2'b00,
    SPFM_READ = 2'b01,
    SPFM_IACK = 2'b10
  } spfm_host_st_t;

endpackage

// *** rtl/spfm_sync.sv ***
// Two-flop synchroniser for a bundle of slow pin levels
`timescale 1ns/1ps
module spfm_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,     // System clock
  input  wire logic         presetn,  // Asynchronous reset, active low
  input  wire logic [W-1:0] d_async,  // Pin levels
  output logic      [W-1:0] q_sync    // Levels safe to use
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d_async;
      sync_ff <= meta_ff;
    end
  end

  assign q_sync = sync_ff;
endmodule // spfm_sync

// *** testbench/spfm_link_checker.sv ***
// Concurrent checks on the backplane link between the two ends
`timescale 1ns/1ps
module spfm_link_checker (
  input wire logic        pclk,      // System clock
  input wire logic        presetn,   // Asynchronous reset, active low
  input wire logic        rd_req,    // Read request
  input wire logic [7:0]  rd_la,     // Target logical address
  input wire logic [7:0]  rd_off,    // Register offset
  input wire logic        iack_req,  // Acknowledge cycle
  input wire logic [2:0]  iack_lvl,  // Level being acknowledged
  input wire logic        dev_ack,   // Module answer
  input wire logic [15:0] dev_data,  // Answer data
  input wire logic [7:1]  irq_out,   // Request line output values
  input wire logic [7:1]  irq_oe     // Request line enables
);
  // Read answers are required at the default address 8 only; answer data is checked at any address
  localparam logic [7:0] LADDR = 8'h08;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ack_pulse_a: assert property (dev_ack |=> !dev_ack)
    else $error("answer pulse longer than one cycle");
  rd_answer_a: assert property (rd_req && !iack_req && rd_la == LADDR
    && !dev_ack |=> dev_ack)
    else $error("read of own address not answered next cycle");
  off_data_a: assert property (dev_ack && $past(rd_req && !iack_req)
    && $past(rd_off) != spfm_pkg::STAT_OFF |-> dev_data == 16'h0000)
    else $error("read of other offset returned nonzero data");
  stat_form_a: assert property (dev_ack && !($past(rd_req) &&
    $past(rd_off) != spfm_pkg::STAT_OFF) |-> (dev_data & 16'hf01f) == 16'h400c
    && (dev_data[5] || dev_data[11:6] == 6'h00))
    else $error("status word fixed bits or input gating wrong");
  data_hold_a: assert property (!dev_ack |-> $stable(dev_data))
    else $error("answer data changed without an answer");
  drive_low_a: assert property (irq_out == 7'h00 && $onehot0(irq_oe))
    else $error("request lines not open drain on one level");
  iack_ans_a: assert property (iack_req && !rd_req && iack_lvl != 3'h0
    && irq_oe[iack_lvl] && !dev_ack |=> dev_ack)
    else $error("acknowledge at requested level not answered");
  oe_clear_a: assert property (dev_ack && $past(iack_req)
    |=> irq_oe == 7'h00)
    else $error("request not withdrawn after acknowledge");
  oe_hold_a: assert property (irq_oe != 7'h00 && !dev_ack
    |=> $stable(irq_oe))
    else $error("request changed before acknowledge");

  cover property (rd_req && dev_ack);
  cover property (iack_req && dev_ack);
  cover property (irq_oe[7]);
endmodule // spfm_link_checker

// *** testbench/spfm_tb.sv ***
// Bench joining both ends over the link, driven through APB
`timescale 1ns/1ps
module spfm_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] q;
  logic        pready;
  logic        pslverr;
  logic        serr;
  logic        irq;
  logic        fault;
  logic [6:0]  det_raw;
  logic [6:0]  led_on;
  logic [2:0]  lvl_sel;
  logic [7:0]  laddr_sel;
  logic [15:0] exp_st;
  int          err_count;
  int          n_tests;

  spfm_link_if u_spfm_link_if ();
  spfm_dev_end u_spfm_dev_end (.pclk(pclk), .presetn(presetn),
    .link(u_spfm_link_if), .det_raw(det_raw), .req_lvl_sel(lvl_sel),
    .ack_lvl_sel(lvl_sel),
    .laddr_sel(laddr_sel), .led_on(led_on), .fault(fault));
  spfm_host_end u_spfm_host_end (.pclk(pclk), .presetn(presetn),
    .link(u_spfm_link_if), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  spfm_link_checker u_spfm_link_checker (.pclk(pclk), .presetn(presetn),
    .rd_req(u_spfm_link_if.rd_req), .rd_la(u_spfm_link_if.rd_la),
    .rd_off(u_spfm_link_if.rd_off), .iack_req(u_spfm_link_if.iack_req),
    .iack_lvl(u_spfm_link_if.iack_lvl), .dev_ack(u_spfm_link_if.dev_ack),
    .dev_data(u_spfm_link_if.dev_data), .irq_out(u_spfm_link_if.irq_out),
    .irq_oe(u_spfm_link_if.irq_oe));

  always #25 pclk = ~pclk;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Start a link read, then poll busy until the data lands
  task host_read(input logic [7:0] la, input logic [7:0] off,
                 input logic [15:0] exp);
    apb(spfm_pkg::HREG_CTRL, 1'b1, {15'h0, 1'b1, off, la});
    q = 32'h0001_0000;
    while (q[spfm_pkg::BUSY_BIT] !== 1'b0)
      apb(spfm_pkg::HREG_RDATA, 1'b0, 32'h0);
    chk(q, {16'h0, exp});
  endtask

  task irq_is(input logic exp);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'(exp));
  endtask

  task test_done;
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    test_done;
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    det_raw = 7'h00;
    lvl_sel = 3'h0;
    laddr_sel = 8'h00;
    err_count = 0;
    n_tests = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(spfm_pkg::HREG_CTRL, 1'b0, 32'h0);
    chk(q, 32'h0000_0408);
    apb(8'h20, 1'b0, 32'h0);
    chk(32'(serr), 32'h1);
    chk(q, 32'h0);
    det_raw <= 7'h7f;
    repeat (4) @(posedge pclk);
    chk(32'(led_on), 32'h7f);
    host_read(8'h08, spfm_pkg::STAT_OFF, 16'h4fec);
    host_read(8'h08, 8'h00, 16'h0000);
    irq_is(1'b0);
    apb(spfm_pkg::HREG_IMASK, 1'b1, 32'h1);
    irq_is(1'b1);
    apb(spfm_pkg::HREG_ISTAT, 1'b1, 32'h3);
    irq_is(1'b0);
    apb(spfm_pkg::HREG_IMASK, 1'b1, 32'h2);
    // Channel i is lost while the jumpers select level i+1 (0 = default)
    for (int i = 0; i < 7; i++) begin
      lvl_sel <= (i == 0) ? 3'h0 : 3'(i + 1);
      det_raw <= 7'h7f;
      repeat (8) @(posedge pclk);
      chk(32'(fault), 32'h0);
      chk(32'(led_on), 32'h7f);
      apb(spfm_pkg::HREG_ISTAT, 1'b1, 32'h3);
      exp_st = (i == 0) ? 16'h400c : (16'h4fec & ~(16'h1 << (5 + i)));
      det_raw <= 7'h7f & ~(7'h1 << i);
      repeat (12) @(posedge pclk);
      chk(32'(fault), 32'h1);
      chk(32'(led_on), (i == 0) ? 32'h0 : 32'(7'h7f & ~(7'h1 << i)));
      chk(32'(irq), 32'h1);
      apb(spfm_pkg::HREG_VECTOR, 1'b0, 32'h0);
      chk(q, {13'h0, 3'(i + 1), exp_st});
      host_read(8'h08, spfm_pkg::STAT_OFF, exp_st);
      apb(spfm_pkg::HREG_ISTAT, 1'b1, 32'h3);
      irq_is(1'b0);
    end
    // Move the address switch; the module must answer at the new address
    laddr_sel <= 8'h10;
    repeat (4) @(posedge pclk);
    host_read(8'h10, spfm_pkg::STAT_OFF, exp_st);
    test_done;
  end
endmodule // spfm_tb
